//--- logic/rtc_slave_consts.svh
`ifndef RTC_SLAVE_CONSTS_SVH
`define RTC_SLAVE_CONSTS_SVH

// ==========================================================
// Clock and timing
`define CLK_FREQ_MHZ     50
`define POWERUP_NS       10000
`define POWERUP_CYCLES   ((`POWERUP_NS * `CLK_FREQ_MHZ + 999) / 1000)

// ==========================================================
// Addressing
`define DEV_ID_REG       7'h6F
`define DEV_ID_MEM       7'h57
`define RW_BIT           0
`define DIR_READ         1'b1
`define REG_LAST_ADDR    8'h2F
`define PTR_RESET        8'h00
`define MEM_BYTES        128

// ==========================================================
// Buffering and pin sampling
`define BUF_DEPTH        2
`define PIN_SYNC_RESET   3'h3

`endif

//--- logic/rtc_slave_pkg.sv
package rtc_slave_pkg;

    // ======================================================
    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA,
        ST_RACK,
        ST_ACK
    } slave_state_t;

    // Register-space write entry: word address then data
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } wr_entry_t;

endpackage

//--- logic/stream_if.sv
`timescale 1ns/1ps

interface stream_if #(
    parameter int unsigned WIDTH = 16
) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- logic/line_sync.sv
`timescale 1ns/1ps

module line_sync #(
    parameter int unsigned           WIDTH     = 1,
    parameter logic [WIDTH-1:0]      RESET_VAL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // ======================================================
    // Two-stage synchroniser; first stage feeds only the second
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta     <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync;
        end
    end
endmodule

//--- logic/entry_fifo.sv
`timescale 1ns/1ps

module entry_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    stream_if.snk     wr,
    stream_if.src     rd
);
    localparam int unsigned AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("entry_fifo DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wptr;
    logic [AW-1:0]    next_rptr;
    logic [AW:0]      next_count;
    logic             do_push;
    logic             do_pop;

    // ======================================================
    // Honest flags: full stalls the writer, empty hides data
    assign wr.ready = (count != (AW+1)'(DEPTH));
    assign rd.valid = (count != '0);
    assign rd.data  = store[rptr];

    always_comb begin
        do_push    = wr.valid && wr.ready;
        do_pop     = rd.valid && rd.ready;
        next_wptr  = do_push ? AW'(wptr + 1'b1) : wptr;
        next_rptr  = do_pop ? AW'(rptr + 1'b1) : rptr;
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (do_pop && !do_push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
        end
        if (do_push) begin
            store[wptr] <= wr.data;
        end
    end
endmodule

//--- logic/rtc_serial_slave.sv
`timescale 1ns/1ps
`include "rtc_slave_consts.svh"

// Function
// - Bytes travel most significant bit first, both directions.
// - Data line changes only while clock low; high-clock changes mean start/stop.
// - During power-up the data line is released, never driven.
// - Watch lines for start (data falls, clock high); ignore everything before it.
// - Starts seen during the power-up sequence are ignored.
// - Stop (data rises, clock high) ends a transaction and returns to standby.
// - Transmitter releases after eight bits; receiver pulls low on ninth clock.
// - Acknowledge identification byte, word-address byte and each written data byte; a register-space data byte is not acknowledged while the write buffer is full.
// - Identifier 1101111 selects registers, 1010111 selects user memory; acknowledge match.
// - Slave byte low bit: one means read, zero means write.
// - One word-address byte; address counter cleared to zero at power-up.
// - Write is start, identifier, address, one data byte, stop; then standby.
// - 128 bytes of user memory at 00h-7Fh, only via memory identifier.
// - Device is slave only; master starts transfers and drives clock.
// - Keep sending read bytes while master acknowledges; stop ends the read.
// - Read pointer starts at address, advances per byte; registers wrap 2Fh to 00h.
// - On backup supply the serial interface is disabled.
module rtc_serial_slave #(
    parameter int unsigned POWERUP_CYCLES = `POWERUP_CYCLES,
    parameter int unsigned MEM_BYTES      = `MEM_BYTES,
    parameter int unsigned BUF_DEPTH      = `BUF_DEPTH
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe_out,
    input  wire logic                  backup_mode_in,
    output logic [7:0]                 reg_rd_addr_out,
    input  wire logic [7:0]            reg_rd_data_in,
    output logic                       reg_wr_valid_out,
    input  wire logic                  reg_wr_ready_in,
    output logic [7:0]                 reg_wr_addr_out,
    output logic [7:0]                 reg_wr_data_out,
    output rtc_slave_pkg::slave_state_t state_out
);
    import rtc_slave_pkg::*;

    localparam int unsigned MEM_AW = $clog2(MEM_BYTES);
    localparam int unsigned PU_W   = $clog2(POWERUP_CYCLES + 1);
    localparam logic [7:0]  MEM_MASK = 8'(MEM_BYTES - 1);

    generate
        if (MEM_BYTES < 2 || MEM_BYTES > 256 || (MEM_BYTES & (MEM_BYTES - 1)) != 0)
        begin : g_bad_mem
            $error("rtc_serial_slave MEM_BYTES must be a power of two up to 256");
        end
        if (POWERUP_CYCLES < 1) begin : g_bad_pu
            $error("rtc_serial_slave POWERUP_CYCLES must be at least 1");
        end
    endgenerate

    // ==========================================================
    // Pin sampling and bus condition detection
    logic scl_s;
    logic sda_s;
    logic backup_s;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    line_sync #(
        .WIDTH     (3),
        .RESET_VAL (`PIN_SYNC_RESET)
    ) u_pin_sync (
        .clk_in   (ref_clk_in),
        .rst_n_in (rst_n_in),
        .async_in ({backup_mode_in, scl_in, sda_in}),
        .sync_out ({backup_s, scl_s, sda_s})
    );

    assign scl_rise   = scl_s && !scl_q;
    assign scl_fall   = !scl_s && scl_q;
    assign start_seen = scl_s && scl_q && sda_q && !sda_s;
    assign stop_seen  = scl_s && scl_q && !sda_q && sda_s;

    // ==========================================================
    // Write buffer toward the register space
    stream_if #(.WIDTH(16)) push_if ();
    stream_if #(.WIDTH(16)) pop_if ();

    entry_fifo #(
        .WIDTH (16),
        .DEPTH (BUF_DEPTH)
    ) u_wr_fifo (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .wr         (push_if),
        .rd         (pop_if)
    );

    wr_entry_t pop_entry;

    assign pop_entry        = wr_entry_t'(pop_if.data);
    assign pop_if.ready     = reg_wr_ready_in;
    assign reg_wr_valid_out = pop_if.valid;
    assign reg_wr_addr_out  = pop_entry.addr;
    assign reg_wr_data_out  = pop_entry.data;

    // ==========================================================
    // Slave state
    logic [7:0]     mem [MEM_BYTES];
    slave_state_t   state;
    slave_state_t   after_ack;
    logic [2:0]     bit_cnt;
    logic [7:0]     shifter;
    logic [7:0]     ptr;
    logic           sel_mem;
    logic           phase;
    logic           master_ack;
    logic           oe;
    logic [PU_W-1:0] pu_cnt;
    logic           pu_done;

    slave_state_t   next_state;
    slave_state_t   next_after_ack;
    logic [2:0]     next_bit_cnt;
    logic [7:0]     next_shifter;
    logic [7:0]     next_ptr;
    logic           next_sel_mem;
    logic           next_phase;
    logic           next_master_ack;
    logic           next_oe;
    logic [PU_W-1:0] next_pu_cnt;
    logic           next_pu_done;

    logic [7:0]     rx_byte;
    logic [7:0]     rd_byte;
    logic [7:0]     ptr_inc;
    logic           mem_we;
    logic           push_valid;

    // Device only ever pulls low; the pull-up makes the high level
    assign sda_out         = 1'b0;
    assign sda_oe_out      = oe;
    assign reg_rd_addr_out = ptr;
    assign state_out       = state;
    assign push_if.valid   = push_valid;
    assign push_if.data    = {ptr, rx_byte};

    assign rx_byte = {shifter[6:0], sda_s};
    assign rd_byte = sel_mem ? mem[ptr[MEM_AW-1:0]] : reg_rd_data_in;

    // Memory wraps at its size, register space at its last location
    assign ptr_inc = sel_mem ? (8'(ptr + 8'h01) & MEM_MASK)
                   : ((ptr == `REG_LAST_ADDR) ? `PTR_RESET : 8'(ptr + 8'h01));

    // ==========================================================
    // Next-state logic; the data-line drive is turned on only on falling clock edges
    always_comb begin
        next_state      = state;
        next_after_ack  = after_ack;
        next_bit_cnt    = bit_cnt;
        next_shifter    = shifter;
        next_ptr        = ptr;
        next_sel_mem    = sel_mem;
        next_phase      = phase;
        next_master_ack = master_ack;
        next_oe         = oe;
        mem_we          = 1'b0;
        push_valid      = 1'b0;
        next_pu_cnt     = pu_cnt;
        next_pu_done    = pu_done;

        if (!pu_done) begin
            if (pu_cnt == PU_W'(POWERUP_CYCLES - 1)) begin
                next_pu_done = 1'b1;
            end else begin
                next_pu_cnt = PU_W'(pu_cnt + 1'b1);
            end
        end

        case (state)
            ST_IDLE: begin
            end
            ST_DEV: begin
                if (scl_rise) begin
                    next_shifter = rx_byte;
                    next_bit_cnt = 3'(bit_cnt + 1'b1);
                    if (bit_cnt == 3'h7) begin
                        next_bit_cnt = 3'h0;
                        next_phase   = 1'b0;
                        if (rx_byte[7:1] == `DEV_ID_REG || rx_byte[7:1] == `DEV_ID_MEM) begin
                            next_sel_mem = (rx_byte[7:1] == `DEV_ID_MEM);
                            next_state   = ST_ACK;
                            // Read keeps the pointer left by a dummy write
                            next_after_ack = (rx_byte[`RW_BIT] == `DIR_READ)
                                           ? ST_RDATA : ST_ADDR;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
            end
            ST_ADDR: begin
                if (scl_rise) begin
                    next_shifter = rx_byte;
                    next_bit_cnt = 3'(bit_cnt + 1'b1);
                    if (bit_cnt == 3'h7) begin
                        next_bit_cnt   = 3'h0;
                        next_phase     = 1'b0;
                        next_ptr       = sel_mem ? (rx_byte & MEM_MASK) : rx_byte;
                        next_state     = ST_ACK;
                        next_after_ack = ST_WDATA;
                    end
                end
            end
            ST_WDATA: begin
                if (scl_rise) begin
                    next_shifter = rx_byte;
                    next_bit_cnt = 3'(bit_cnt + 1'b1);
                    if (bit_cnt == 3'h7) begin
                        next_bit_cnt   = 3'h0;
                        next_phase     = 1'b0;
                        next_after_ack = ST_IDLE;
                        if (sel_mem) begin
                            mem_we     = 1'b1;
                            next_state = ST_ACK;
                        end else if (push_if.ready) begin
                            push_valid = 1'b1;
                            next_state = ST_ACK;
                        end else begin
                            // Full buffer: refuse the byte rather than lose it
                            next_state = ST_IDLE;
                        end
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall && !phase) begin
                    next_oe    = 1'b1;
                    next_phase = 1'b1;
                end else if (scl_fall && phase) begin
                    next_phase = 1'b0;
                    next_state = after_ack;
                    next_oe    = 1'b0;
                    if (after_ack == ST_RDATA) begin
                        next_shifter = rd_byte;
                        next_oe      = !rd_byte[7];
                        next_ptr     = ptr_inc;
                        next_bit_cnt = 3'h0;
                    end
                end
            end
            ST_RDATA: begin
                if (scl_fall) begin
                    next_shifter = {shifter[6:0], 1'b0};
                    next_oe      = !shifter[6];
                end
                if (scl_rise) begin
                    next_bit_cnt = 3'(bit_cnt + 1'b1);
                    if (bit_cnt == 3'h7) begin
                        next_bit_cnt = 3'h0;
                        next_phase   = 1'b0;
                        next_state   = ST_RACK;
                    end
                end
            end
            ST_RACK: begin
                if (scl_fall && !phase) begin
                    next_oe = 1'b0;
                end else if (scl_rise) begin
                    next_phase      = 1'b1;
                    next_master_ack = !sda_s;
                end else if (scl_fall && phase) begin
                    next_phase = 1'b0;
                    if (master_ack) begin
                        next_state   = ST_RDATA;
                        next_shifter = rd_byte;
                        next_oe      = !rd_byte[7];
                        next_ptr     = ptr_inc;
                        next_bit_cnt = 3'h0;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_oe    = 1'b0;
            end
        endcase

        if (stop_seen) begin
            next_state = ST_IDLE;
            next_oe    = 1'b0;
        end
        if (start_seen) begin
            next_state   = ST_DEV;
            next_bit_cnt = 3'h0;
            next_phase   = 1'b0;
            next_oe      = 1'b0;
        end
        if (!pu_done || backup_s) begin
            next_state = ST_IDLE;
            next_oe    = 1'b0;
        end
    end

    // ==========================================================
    // Registers; user memory keeps its contents across reset
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            state      <= ST_IDLE;
            after_ack  <= ST_IDLE;
            bit_cnt    <= 3'h0;
            shifter    <= 8'h00;
            ptr        <= `PTR_RESET;
            sel_mem    <= 1'b0;
            phase      <= 1'b0;
            master_ack <= 1'b0;
            oe         <= 1'b0;
            pu_cnt     <= '0;
            pu_done    <= 1'b0;
        end else begin
            scl_q      <= scl_s;
            sda_q      <= sda_s;
            state      <= next_state;
            after_ack  <= next_after_ack;
            bit_cnt    <= next_bit_cnt;
            shifter    <= next_shifter;
            ptr        <= next_ptr;
            sel_mem    <= next_sel_mem;
            phase      <= next_phase;
            master_ack <= next_master_ack;
            oe         <= next_oe;
            pu_cnt     <= next_pu_cnt;
            pu_done    <= next_pu_done;
        end
        if (mem_we) begin
            mem[ptr[MEM_AW-1:0]] <= rx_byte;
        end
    end
endmodule

//--- sim/rtc_bus_master.sv
`timescale 1ns/1ps

module rtc_bus_master (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // ====
    // Phase driver: each phase holds two clocks; clock idles high between frames
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic ph(input logic c, input logic l);
        scl_out     = c;
        sda_low_out = l;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    // Keeps the current clock level first so an idle bus sees no stray pulse
    task automatic start();
        ph(scl_out, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
        ph(1'b0, 1'b1);
    endtask
    task automatic stop();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    // Nine bits: a 1 releases the line, so reads and acks share one path
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, !tx[i]);
            ph(1'b1, !tx[i]);
            rx[i] = sda_in;
            ph(1'b1, !tx[i]);
            ph(1'b0, !tx[i]);
        end
    endtask
endmodule

//--- sim/rtc_serial_slave_monitor.sv
`timescale 1ns/1ps

module rtc_serial_slave_monitor
    import rtc_slave_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = 500
) (
    input wire logic                        ref_clk_in,
    input wire logic                        rst_n_in,
    input wire logic                        scl_in,
    input wire logic                        backup_mode_in,
    input wire logic                        sda_out,
    input wire logic                        sda_oe_out,
    input wire logic                        reg_wr_valid_out,
    input wire logic                        reg_wr_ready_in,
    input wire logic [7:0]                  reg_wr_addr_out,
    input wire logic [7:0]                  reg_wr_data_out,
    input wire rtc_slave_pkg::slave_state_t state_out
);
    // ====
    // Cycles since reset release, saturating
    logic [15:0] up_cnt;
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            up_cnt <= 16'h0000;
        end else if (up_cnt != 16'hFFFF) begin
            up_cnt <= up_cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence scl_high_held;
        scl_in [*4];
    endsequence
    sequence backup_held;
        backup_mode_in [*5];
    endsequence
    sequence idle_held;
        (state_out == ST_IDLE) [*8];
    endsequence
    rst_release_a: assert property ($rose(rst_n_in) |-> !sda_oe_out && !reg_wr_valid_out)
        else $error("outputs active at reset release");
    idle_at_release_a: assert property ($rose(rst_n_in) |-> state_out == ST_IDLE)
        else $error("state not idle at reset release");
    pull_only_a: assert property (sda_oe_out |-> !sda_out
        && (state_out inside {ST_ACK, ST_RDATA, ST_RACK}))
        else $error("data line driven outside ack or read");
    powerup_quiet_a: assert property ((up_cnt < POWERUP_CYCLES) |-> !sda_oe_out)
        else $error("data line driven in power-up window");
    oe_scl_low_a: assert property (scl_high_held |-> $stable(sda_oe_out))
        else $error("drive changed while clock high");
    backup_quiet_a: assert property (backup_held |-> !sda_oe_out)
        else $error("data line driven on backup supply");
    wr_hold_a: assert property (reg_wr_valid_out && !reg_wr_ready_in |=> reg_wr_valid_out
        && $stable(reg_wr_addr_out) && $stable(reg_wr_data_out))
        else $error("write entry changed before taken");
    wr_drop_a: assert property ($fell(reg_wr_valid_out) |-> $past(reg_wr_ready_in))
        else $error("write entry dropped untaken");
    idle_quiet_a: assert property (idle_held |-> !sda_oe_out)
        else $error("data line driven while idle");
    ack_bounded_a: assert property ($rose(sda_oe_out) |-> ##[1:80] !sda_oe_out)
        else $error("data line held past one byte");
endmodule

bind rtc_serial_slave rtc_serial_slave_monitor #(
    .POWERUP_CYCLES(POWERUP_CYCLES)
) i_rtc_serial_slave_monitor (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl_in),
    .backup_mode_in(backup_mode_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .reg_wr_valid_out(reg_wr_valid_out),
    .reg_wr_ready_in(reg_wr_ready_in),
    .reg_wr_addr_out(reg_wr_addr_out),
    .reg_wr_data_out(reg_wr_data_out),
    .state_out(state_out)
);

//--- sim/rtc_dual_address_serial_slave_test.sv
`timescale 1ns/1ps
`include "rtc_slave_consts.svh"

module rtc_dual_address_serial_slave_test;
    localparam int unsigned PWR   = 200;
    localparam logic [7:0]  REG_W = {`DEV_ID_REG, 1'b0};
    localparam logic [7:0]  REG_R = {`DEV_ID_REG, `DIR_READ};
    localparam logic [7:0]  MEM_W = {`DEV_ID_MEM, 1'b0};
    localparam logic [7:0]  MEM_R = {`DEV_ID_MEM, `DIR_READ};
    localparam logic [7:0]  MASK  = 8'h5A;
    logic       clk         = 1'b0;
    logic       rst_n       = 1'b0;
    logic       backup      = 1'b0;
    logic       ready       = 1'b0;
    logic       scl;
    logic       m_low;
    logic       oe;
    logic       wr_valid;
    logic [7:0] rd_addr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    wire  logic sda         = !(m_low || oe);
    int         miscompares = 0;
    int         check_count = 0;
    int         cycles      = 0;
    // ====
    // Clock, register-space stand-in and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    rtc_bus_master i_rtc_bus_master (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
    rtc_serial_slave #(.POWERUP_CYCLES(PWR)) i_rtc_serial_slave (
        .ref_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe_out(oe), .backup_mode_in(backup), .reg_rd_addr_out(rd_addr),
        .reg_rd_data_in(rd_addr ^ MASK), .reg_wr_valid_out(wr_valid), .reg_wr_ready_in(ready),
        .reg_wr_addr_out(wr_addr), .reg_wr_data_out(wr_data), .state_out()
    );
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic nak);
        logic [8:0] rx;
        i_rtc_bus_master.xfer({b, 1'b1}, rx);
        check("ack", {7'h00, nak}, {7'h00, rx[0]});
    endtask
    task automatic recv(input logic [7:0] exp, input logic last);
        logic [8:0] rx;
        i_rtc_bus_master.xfer({8'hFF, last}, rx);
        check("rd", exp, rx[8:1]);
        check("rack", {7'h00, last}, {7'h00, rx[0]});
    endtask
    task automatic t_startup();
        i_rtc_bus_master.start();
        send(REG_W, 1'b1);
        i_rtc_bus_master.stop();
        check("oe", 8'h00, {7'h00, oe});
        repeat (PWR) @(posedge clk);
        #1;
        i_rtc_bus_master.start();
        send(REG_R, 1'b0);
        recv(8'h00 ^ MASK, 1'b1);
        i_rtc_bus_master.stop();
        backup = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        i_rtc_bus_master.start();
        send(REG_W, 1'b1);
        i_rtc_bus_master.stop();
        backup = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic t_bad_id();
        logic [6:0] ids [3] = '{7'h6E, 7'h2F, 7'h17};
        foreach (ids[i]) begin
            i_rtc_bus_master.start();
            send({ids[i], 1'b0}, 1'b1);
            send(8'h00, 1'b1);
            i_rtc_bus_master.stop();
        end
    endtask
    // Consumer stalls throughout, so the third write finds the buffer full
    task automatic t_write();
        for (int k = 0; k < 3; k++) begin
            i_rtc_bus_master.start();
            send(REG_W, 1'b0);
            send(8'h2E + k[7:0], 1'b0);
            send(8'hA5 ^ k[7:0], k == 2);
            send(8'h11, 1'b1);
            i_rtc_bus_master.stop();
        end
        for (int k = 0; k < 2; k++) begin
            check("valid", 8'h01, {7'h00, wr_valid});
            check("waddr", 8'h2E + k[7:0], wr_addr);
            check("wdata", 8'hA5 ^ k[7:0], wr_data);
            ready = 1'b1;
            @(posedge clk);
            #1;
            ready = 1'b0;
        end
        check("valid", 8'h00, {7'h00, wr_valid});
    endtask
    task automatic t_mem();
        logic [7:0] a [2] = '{8'h7F, 8'h00};
        logic [7:0] d [2] = '{8'h3C, 8'hC3};
        foreach (a[i]) begin
            i_rtc_bus_master.start();
            send(MEM_W, 1'b0);
            send(a[i], 1'b0);
            send(d[i], 1'b0);
            i_rtc_bus_master.stop();
        end
        i_rtc_bus_master.start();
        send(MEM_W, 1'b0);
        send(8'h7F, 1'b0);
        i_rtc_bus_master.start();
        send(MEM_R, 1'b0);
        recv(8'h3C, 1'b0);
        recv(8'hC3, 1'b1);
        i_rtc_bus_master.stop();
        check("valid", 8'h00, {7'h00, wr_valid});
    endtask
    task automatic t_wrap();
        i_rtc_bus_master.start();
        send(REG_W, 1'b0);
        send(`REG_LAST_ADDR, 1'b0);
        i_rtc_bus_master.start();
        send(REG_R, 1'b0);
        recv(`REG_LAST_ADDR ^ MASK, 1'b0);
        recv(8'h00 ^ MASK, 1'b1);
        i_rtc_bus_master.stop();
        i_rtc_bus_master.start();
        send(REG_R, 1'b0);
        recv(8'h01 ^ MASK, 1'b1);
        i_rtc_bus_master.stop();
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_startup();
        $display("t_startup done");
        t_bad_id();
        $display("t_bad_id done");
        t_write();
        $display("t_write done");
        t_mem();
        $display("t_mem done");
        t_wrap();
        $display("t_wrap done");
        close_out();
    end
endmodule
